// ### src/sampling_adc_host_interface.sv
// Control and host interface of a two-input sampling converter
`timescale 1ns/10ps
module sampling_adc_host_interface
  import conv_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int EOC_CYCLES = EOC_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Host pins
  input wire host_ctrl_t hostPins,
  // Flash stage results from the analog core
  input wire flash_codes_t flashCodes,
  // Status and data
  output logic convDone,
  output logic resultReadyN,
  output logic [RESULT_W-1:0] dataOut,
  output logic dataOe,
  // Analog core control
  output logic sampleSwitch,
  output logic muxSelect
);
  typedef enum {S_SAMPLE, S_CONVERT, S_DONE} conv_state_t;

  host_ctrl_t pins;
  conv_state_t state_reg;
  logic shPrev_reg;
  logic rdPrev_reg;
  logic [15:0] count_reg;
  logic [RESULT_W-1:0] result_reg;
  logic startConv;
  logic readFall;

  pin_sync #(.W($bits(host_ctrl_t)), .IDLE(PINS_IDLE)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinAsync(hostPins),
    .pinSync(pins)
  );

  function automatic logic [RESULT_W-1:0] combineCodes(input flash_codes_t c);
    combineCodes = {c.flash1, c.flash2, c.flash3};
  endfunction

  // Edge detectors on synchronised strobes; chip select gates both
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shPrev_reg <= 1'b0;
      rdPrev_reg <= 1'b1;
    end else begin
      shPrev_reg <= pins.sampleHold;
      rdPrev_reg <= pins.readN;
    end
  end
  assign startConv = shPrev_reg && !pins.sampleHold && !pins.chipSelN;
  assign readFall = rdPrev_reg && !pins.readN && !pins.chipSelN;

  // Conversion sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= S_SAMPLE;
      count_reg <= '0;
    end else begin
      case (state_reg)
        S_SAMPLE: begin
          if (startConv) begin
            state_reg <= S_CONVERT;
            count_reg <= '0;
          end
        end
        S_CONVERT: begin
          if (count_reg == 16'(CONV_CYCLES - 1)) begin
            state_reg <= S_DONE;
            count_reg <= '0;
          end else begin
            count_reg <= count_reg + 16'h0001;
          end
        end
        S_DONE: begin
          // Done pulse lasts a fixed time, then tracking resumes
          if (count_reg == 16'(EOC_CYCLES - 1)) begin
            state_reg <= S_SAMPLE;
          end else begin
            count_reg <= count_reg + 16'h0001;
          end
        end
        default: state_reg <= S_SAMPLE;
      endcase
    end
  end

  // Switch tracks input only while sampling
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sampleSwitch <= 1'b1;
    end else begin
      sampleSwitch <= (state_reg == S_SAMPLE) && !startConv;
    end
  end

  // Result latch and done flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_reg <= RESULT_RST;
      convDone <= 1'b0;
    end else begin
      if (state_reg == S_CONVERT && count_reg == 16'(CONV_CYCLES - 1)) begin
        result_reg <= combineCodes(flashCodes);
        convDone <= 1'b1;
      end else if (state_reg == S_DONE && count_reg == 16'(EOC_CYCLES - 1)) begin
        convDone <= 1'b0;
      end
    end
  end

  // Ready flag: completion wins over a simultaneous read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resultReadyN <= 1'b1;
    end else if (state_reg == S_CONVERT && count_reg == 16'(CONV_CYCLES - 1)) begin
      resultReadyN <= 1'b0;
    end else if (readFall) begin
      resultReadyN <= 1'b1;
    end
  end

  // Channel taken as done falls, so the next sample sees it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      muxSelect <= CHAN_FIRST;
    end else if (state_reg == S_DONE && count_reg == 16'(EOC_CYCLES - 1)) begin
      muxSelect <= pins.channelSelect ? CHAN_SECOND : CHAN_FIRST;
    end
  end

  // Bus drive: always in high-speed mode, else during an enabled read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataOut <= RESULT_RST;
      dataOe <= 1'b0;
    end else begin
      dataOut <= result_reg;
      dataOe <= pins.highSpeed || (!pins.readN && !pins.chipSelN);
    end
  end

  sequence s_convEnd;
    state_reg == S_CONVERT && count_reg == 16'(CONV_CYCLES - 1);
  endsequence

  sequence s_startSeen;
    startConv && state_reg == S_SAMPLE;
  endsequence

  sequence s_doneEnd;
    state_reg == S_DONE && count_reg == 16'(EOC_CYCLES - 1);
  endsequence

  a_start_holds: assert property (@(posedge clk) disable iff (sys_rst)
    s_startSeen |=> !sampleSwitch)
    else $error("switch not opened at conversion start");
  a_start_converts: assert property (@(posedge clk) disable iff (sys_rst)
    s_startSeen |=> state_reg == S_CONVERT)
    else $error("falling strobe did not start a conversion");
  a_start_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == S_CONVERT && count_reg != 16'(CONV_CYCLES - 1) |=> state_reg == S_CONVERT)
    else $error("conversion cut short");
  a_cs_gates_start: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == S_SAMPLE && pins.chipSelN |=> state_reg == S_SAMPLE)
    else $error("conversion started without chip select");
  a_done_rises: assert property (@(posedge clk) disable iff (sys_rst)
    s_convEnd |=> convDone && !resultReadyN)
    else $error("done or ready missing after conversion");
  a_done_width: assert property (@(posedge clk) disable iff (sys_rst)
    s_doneEnd |=> !convDone)
    else $error("done held too long");
  a_result_latched: assert property (@(posedge clk) disable iff (sys_rst)
    s_convEnd |=> result_reg == {$past(flashCodes.flash1), $past(flashCodes.flash2),
      $past(flashCodes.flash3)})
    else $error("result not latched");
  a_read_clears: assert property (@(posedge clk) disable iff (sys_rst)
    readFall && !(state_reg == S_CONVERT) |=> resultReadyN)
    else $error("read did not clear ready");
  a_ready_holds: assert property (@(posedge clk) disable iff (sys_rst)
    !resultReadyN && !readFall |=> !resultReadyN)
    else $error("ready cleared without a read");
  a_ready_cs: assert property (@(posedge clk) disable iff (sys_rst)
    !resultReadyN && pins.chipSelN |=> !resultReadyN)
    else $error("read honoured without chip select");
  a_highspeed_bus: assert property (@(posedge clk) disable iff (sys_rst)
    pins.highSpeed |=> dataOe && dataOut == $past(result_reg))
    else $error("bus not driven in high-speed mode");
  a_bus_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !pins.highSpeed && (pins.readN || pins.chipSelN) |=> !dataOe)
    else $error("bus driven outside a read");
  a_chan_capture: assert property (@(posedge clk) disable iff (sys_rst)
    convDone ##1 !convDone |-> muxSelect == $past(pins.channelSelect))
    else $error("channel not captured at done fall");
  a_chan_steady: assert property (@(posedge clk) disable iff (sys_rst)
    !(state_reg == S_DONE && count_reg == 16'(EOC_CYCLES - 1)) |=> $stable(muxSelect))
    else $error("channel changed away from done fall");
  a_sample_switch: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == S_CONVERT |-> !sampleSwitch)
    else $error("switch closed during hold");
  a_switch_closed: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == S_SAMPLE && !startConv |=> sampleSwitch)
    else $error("switch open while sampling");
endmodule

// ### src/conv_ctrl_pkg.sv
// Shared constants and carrier types for the converter control block
package conv_ctrl_pkg;
  localparam int RESULT_W = 12;
  localparam int FLASH1_W = 6;
  localparam int FLASH2_W = 4;
  localparam int FLASH3_W = 2;
  localparam int CONV_NS = 740;
  localparam int CLK_NS = 10;
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_CYC = CONV_CYC / 3;
  localparam int EOC_NS = 60;
  localparam int EOC_CYC = (EOC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
  localparam logic CHAN_FIRST = 1'b0;
  localparam logic CHAN_SECOND = 1'b1;

  typedef struct packed {
    logic sampleHold;
    logic chipSelN;
    logic readN;
    logic channelSelect;
    logic highSpeed;
  } host_ctrl_t;

  // Levels an undriven host presents; the synchroniser resets to these
  localparam host_ctrl_t PINS_IDLE = '{sampleHold: 1'b1, chipSelN: 1'b1, readN: 1'b1,
    channelSelect: CHAN_FIRST, highSpeed: 1'b0};

  typedef struct packed {
    logic [FLASH1_W-1:0] flash1;
    logic [FLASH2_W-1:0] flash2;
    logic [FLASH3_W-1:0] flash3;
  } flash_codes_t;
endpackage

// ### src/pin_sync.sv
// Two flip-flop synchroniser for a bundle of pins
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 5,
  // Reset to idle pin levels, so no false edge follows reset
  parameter logic [W-1:0] IDLE = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins
  input wire logic [W-1:0] pinAsync,
  output logic [W-1:0] pinSync
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1_reg <= IDLE;
      pinSync <= IDLE;
    end else begin
      stage1_reg <= pinAsync;
      pinSync <= stage1_reg;
    end
  end
endmodule

// ### tb/host_model.sv
// Host side model that turns bench requests into control pins
`timescale 1ns/10ps
module host_model
  import conv_ctrl_pkg::*;
(
  // Requests
  input wire logic startConv,
  input wire logic readReq,
  input wire logic chan,
  input wire logic hs,
  input wire logic selN,
  // Pins
  output host_ctrl_t pins
);
  always_comb begin
    pins.sampleHold = !startConv;
    pins.chipSelN = selN;
    // Fast host never ends its read
    pins.readN = !(readReq || hs);
    pins.channelSelect = chan;
    pins.highSpeed = hs;
  end
endmodule

// ### tb/sampling_adc_host_interface_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module sampling_adc_host_interface_test;
  import conv_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic startConv = 1'b0, readReq = 1'b0, chan = 1'b0, hs = 1'b0, selN = 1'b0;
  flash_codes_t codes = '0;
  host_ctrl_t pins;
  logic convDone, readyN, oe, sw, mux;
  logic [RESULT_W-1:0] dataOut;
  logic [RESULT_W-1:0] expQ[$];
  logic chanQ[$];
  logic [31:0] seed = 32'h00000048;
  int n_errors = 0;
  int checks_done = 0;

  host_model host (.startConv(startConv), .readReq(readReq), .chan(chan), .hs(hs),
    .selN(selN), .pins(pins));
  // Short counts keep the run brief
  sampling_adc_host_interface #(.CONV_CYCLES(3), .EOC_CYCLES(1)) dut (.clk(clk),
    .sys_rst(rst), .hostPins(pins), .flashCodes(codes), .convDone(convDone),
    .resultReadyN(readyN), .dataOut(dataOut), .dataOe(oe), .sampleSwitch(sw),
    .muxSelect(mux));

  initial forever #5 clk = ~clk;

  task automatic stop_test();
    $display("Errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask

  task automatic chkData(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t data %h", $time, got);
    end
  endtask

  task automatic conv(input logic c, input logic s);
    seed = xs(seed);
    @(negedge clk);
    codes = flash_codes_t'(seed[RESULT_W-1:0]);
    chan = c;
    selN = s;
    if (!s) begin
      expQ.push_back({codes.flash1, codes.flash2, codes.flash3});
      chanQ.push_back(c);
    end
    @(negedge clk);
    startConv = 1'b1;
    repeat (5) @(negedge clk);
    chk(sw, s, "switch");
    startConv = 1'b0;
    repeat (15) @(negedge clk);
  endtask

  task automatic rd(input logic s, input logic exp);
    @(negedge clk);
    selN = s;
    readReq = 1'b1;
    repeat (4) @(negedge clk);
    chk(readyN, exp, "ready clear");
    chk(oe, exp, "bus enable");
    readReq = 1'b0;
    selN = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Results are paired with the oldest note
  initial begin
    forever begin
      @(posedge convDone);
      @(negedge clk);
      chk(readyN, 1'b0, "ready");
      chk(convDone, 1'b1, "done");
      @(negedge clk);
      chk(convDone, 1'b0, "done width");
      if (expQ.size() == 0) chk(1'b0, 1'b1, "extra result");
      else chkData(dataOut, expQ.pop_front());
      repeat (2) @(negedge clk);
      chk(mux, chanQ.pop_front(), "channel");
    end
  end

  initial begin
    #10000;
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      conv(i[0], 1'b0);
      rd(1'b1, 1'b0);
      rd(1'b0, 1'b1);
    end
    conv(1'b1, 1'b1);
    hs = 1'b1;
    conv(1'b0, 1'b0);
    chk(oe, 1'b1, "fast bus");
    stop_test();
  end
endmodule
